//--- design/phy_mac_data_port.sv
// mac-side data port of one transceiver channel: transmit sampling,
// transmit and receive latencies, carrier sense and receive clock.
// assumes the mac clocks tx data on link_clk_i and the line coder
// and decoder run on clk_i (one cycle per 100 Mb/s bit).
// Overview of operation
// - J group 5 bits after tx start
// - T group 5 bits after tx end
// - crs on 20 bits after J, data 24 bits after the line
// - no reception without signal detect
// - crs off 24 bits after T
// - 100 Mb/s bit time is 10 ns
// - 10 Mb/s mii samples on falling edge
// - 10 Mb/s output 3.5 bits after edge
// - rx clock switch never shortens phase
`timescale 1ns/10ps
`default_nettype none

// dual-clock fifo with gray-coded pointers
module phy_async_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 32
) (
  // write side
  input wire logic wr_clk_i,
  input wire logic wr_rst_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read side
  input wire logic rd_clk_i,
  input wire logic rd_rst_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW:0] wbin_reg, wbin_next, wgray_reg, wgray_next;
  logic [AW:0] rbin_reg, rbin_next, rgray_reg, rgray_next;
  logic [AW:0] rg_meta_reg, rg_sync_reg;  // read pointer in write domain
  logic [AW:0] wg_meta_reg, wg_sync_reg;  // write pointer in read domain
  logic do_wr, do_rd;

  // write pointer and full flag
  always_comb
  begin
    wr_ready_o = (wgray_reg != {~rg_sync_reg[AW:AW-1], rg_sync_reg[AW-2:0]});
    do_wr = wr_valid_i & wr_ready_o;
    wbin_next = wbin_reg + {{AW{1'b0}}, do_wr};
    wgray_next = wbin_next ^ (wbin_next >> 1);
  end

  // write domain registers
  always_ff @(posedge wr_clk_i)
  begin
    if (wr_rst_i)
    begin
      wbin_reg <= '0;
      wgray_reg <= '0;
      rg_meta_reg <= '0;
      rg_sync_reg <= '0;
    end
    else
    begin
      wbin_reg <= wbin_next;
      wgray_reg <= wgray_next;
      rg_meta_reg <= rgray_reg;
      rg_sync_reg <= rg_meta_reg;
    end
  end

  // storage write
  always_ff @(posedge wr_clk_i)
  begin
    if (do_wr)
      mem[wbin_reg[AW-1:0]] <= wr_data_i;
  end

  // read pointer and empty flag
  always_comb
  begin
    rd_valid_o = (rgray_reg != wg_sync_reg);
    rd_data_o = mem[rbin_reg[AW-1:0]];
    do_rd = rd_valid_o & rd_ready_i;
    rbin_next = rbin_reg + {{AW{1'b0}}, do_rd};
    rgray_next = rbin_next ^ (rbin_next >> 1);
  end

  // read domain registers
  always_ff @(posedge rd_clk_i)
  begin
    if (rd_rst_i)
    begin
      rbin_reg <= '0;
      rgray_reg <= '0;
      wg_meta_reg <= '0;
      wg_sync_reg <= '0;
    end
    else
    begin
      rbin_reg <= rbin_next;
      rgray_reg <= rgray_next;
      wg_meta_reg <= wgray_reg;
      wg_sync_reg <= wg_meta_reg;
    end
  end
endmodule

module phy_mac_data_port
  import mii_lat_pkg::*;
(
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // mode pins
  input wire logic speed_10_i,
  input wire logic serial_mode_i,
  // mac transmit side
  input wire logic link_clk_i,
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  output logic tx_fifo_ready_o,
  // line transmit side
  output logic line_tx_bit_o,
  output logic [1:0] line_tx_sym_o,
  // line receive side
  input wire logic signal_detect_i,
  input wire logic line_rx_bit_i,
  input wire logic [1:0] line_rx_sym_i,
  // mac receive side
  output logic crs_o,
  output logic rx_dv_o,
  output logic rx_bit_o,
  output logic rx_clk_o
);
  typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_J, TX_DATA, TX_T} tx_state_e;
  typedef enum logic [1:0] {CRS_IDLE, CRS_ON_WAIT, CRS_CARRIER, CRS_OFF_WAIT} crs_state_e;

  // link domain
  logic lrst_meta_reg, lrst_reg;  // reset carried into link domain
  logic [1:0] lmode_meta_reg, lmode_reg;  // {serial, speed10}
  logic [4:0] neg_smp_reg;  // falling edge sample
  logic [4:0] pos_smp_reg;  // rising edge sample
  logic prev_en_reg, prev_en_next;
  logic [4:0] sel_smp;
  logic push;
  // fifo read side
  logic f_valid, f_ready;
  logic [4:0] f_data;
  // clk domain mode and detect synchronisers
  logic [1:0] mode_meta_reg, mode_reg;
  logic sd_meta_reg, sd_reg;
  logic slow;
  // transmit path
  tx_state_e tx_state_reg, tx_state_next;
  cnt_t tx_cnt_reg, tx_cnt_next;
  logic [1:0] tx_bits_reg, tx_bits_next;  // bits left in nibble
  logic [3:0] tx_sh_reg, tx_sh_next;
  logic tx_bit_reg, tx_bit_next;
  line_sym_e tx_sym_reg, tx_sym_next;
  cnt_t bit_cyc, lead_cyc;
  logic [1:0] nib_bits;
  // receive path
  crs_state_e crs_state_reg, crs_state_next;
  cnt_t crs_cnt_reg, crs_cnt_next;
  logic crs_reg, crs_next;
  // stage 0 holds the sampled marker, then one stage per bit time
  logic [RX_DATA_CYC:0] dv_pipe_reg, dv_pipe_next;
  logic [RX_DATA_CYC:0] bit_pipe_reg, bit_pipe_next;
  logic in_dv;
  // receive clock
  logic rxclk_reg, rxclk_next;
  cnt_t rxclk_cnt_reg, rxclk_cnt_next;
  logic src_reg, src_next;  // 1 while on recovered clock
  cnt_t half_cyc;

  // link domain synchronisers for reset and mode pins
  always_ff @(posedge link_clk_i)
  begin
    lrst_meta_reg <= rst_i;
    lrst_reg <= lrst_meta_reg;
    lmode_meta_reg <= {serial_mode_i, speed_10_i};
    lmode_reg <= lmode_meta_reg;
  end

  always_ff @(negedge link_clk_i)
  begin
    neg_smp_reg <= {tx_en_i, txd_i};
  end

  // pick the sample edge and push words plus one end marker
  always_comb
  begin
    // 10 Mb/s mii uses the falling sample, others rising
    sel_smp = (lmode_reg == 2'b01) ? neg_smp_reg : pos_smp_reg;
    push = sel_smp[4] | prev_en_reg;
    // a refused end marker is retried, so an overflow never hides a frame end
    prev_en_next = sel_smp[4] | (prev_en_reg & ~tx_fifo_ready_o);
  end

  // rising edge capture and frame tracking
  always_ff @(posedge link_clk_i)
  begin
    pos_smp_reg <= {tx_en_i, txd_i};
    if (lrst_reg)
      prev_en_reg <= 1'b0;
    else
      prev_en_reg <= prev_en_next;
  end

  // transmit words cross into clk_i here
  phy_async_fifo #(
    .WIDTH(TXF_WIDTH),
    .DEPTH(TXF_DEPTH)
  ) u_txf (
    .wr_clk_i(link_clk_i),
    .wr_rst_i(lrst_reg),
    .wr_valid_i(push),
    .wr_ready_o(tx_fifo_ready_o),
    .wr_data_i(sel_smp),
    .rd_clk_i(clk_i),
    .rd_rst_i(rst_i),
    .rd_valid_o(f_valid),
    .rd_ready_i(f_ready),
    .rd_data_o(f_data)
  );

  // mode pins and signal detect into clk_i
  always_ff @(posedge clk_i)
  begin
    mode_meta_reg <= {serial_mode_i, speed_10_i};
    mode_reg <= mode_meta_reg;
    sd_meta_reg <= signal_detect_i;
    sd_reg <= sd_meta_reg;
  end

  // transmit serialiser next state
  always_comb
  begin
    slow = mode_reg[0];
    // one cycle per bit at 100 Mb/s, 100 ns bits at 10 Mb/s
    bit_cyc = slow ? cnt_t'(BIT_10_CYC) : cnt_t'(BIT_100_CYC);
    // start delay, 3.5 bits at 10 Mb/s
    lead_cyc = slow ? cnt_t'(TX10_START_CYC) : cnt_t'(TX100_START_CYC);
    nib_bits = mode_reg[1] ? 2'h0 : 2'h3;
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bits_next = tx_bits_reg;
    tx_sh_next = tx_sh_reg;
    tx_bit_next = tx_bit_reg;
    tx_sym_next = tx_sym_reg;
    f_ready = 1'b0;
    case (tx_state_reg)
      TX_IDLE:
      begin
        // first word opens a frame, a stray end marker is dropped
        f_ready = 1'b1;
        if (f_valid && f_data[4])
        begin
          tx_sh_next = f_data[3:0];
          tx_cnt_next = lead_cyc - 8'h01;
          tx_state_next = TX_LEAD;
        end
      end
      TX_LEAD:
      begin
        // count out the start latency
        tx_cnt_next = tx_cnt_reg - 8'h01;
        if (tx_cnt_reg == CNT_RESET)
        begin
          tx_cnt_next = bit_cyc - 8'h01;
          if (slow)
          begin
            tx_state_next = TX_DATA;
            tx_bits_next = nib_bits;
            tx_bit_next = tx_sh_reg[0];
            tx_sym_next = SYM_DATA;
          end
          else
          begin
            tx_cnt_next = cnt_t'(CODE_GROUP_CYC) - 8'h01;
            tx_state_next = TX_J;
            tx_sym_next = SYM_J;
          end
        end
      end
      TX_J:
      begin
        tx_cnt_next = tx_cnt_reg - 8'h01;
        if (tx_cnt_reg == CNT_RESET)
        begin
          tx_cnt_next = bit_cyc - 8'h01;
          tx_state_next = TX_DATA;
          tx_bits_next = nib_bits;
          tx_bit_next = tx_sh_reg[0];
          tx_sym_next = SYM_DATA;
        end
      end
      TX_DATA:
      begin
        if (tx_cnt_reg != CNT_RESET)
          tx_cnt_next = tx_cnt_reg - 8'h01;
        else if (tx_bits_reg != 2'h0)
        begin
          // next bit of the same nibble
          tx_bits_next = tx_bits_reg - 2'h1;
          tx_sh_next = tx_sh_reg >> 1;
          tx_bit_next = tx_sh_reg[1];
          tx_cnt_next = bit_cyc - 8'h01;
        end
        else
        begin
          // nibble done: take the next word, wait if none yet
          f_ready = 1'b1;
          if (f_valid && f_data[4])
          begin
            tx_sh_next = f_data[3:0];
            tx_bits_next = nib_bits;
            tx_bit_next = f_data[0];
            tx_cnt_next = bit_cyc - 8'h01;
          end
          else if (f_valid && slow)
          begin
            tx_state_next = TX_IDLE;
            tx_sym_next = SYM_IDLE;
            tx_bit_next = 1'b0;
          end
          else if (f_valid)
          begin
            // end-of-stream group follows the last data
            tx_cnt_next = cnt_t'(TX100_END_CYC) - 8'h01;
            tx_state_next = TX_T;
            tx_sym_next = SYM_T;
            tx_bit_next = 1'b0;
          end
        end
      end
      TX_T:
      begin
        tx_cnt_next = tx_cnt_reg - 8'h01;
        if (tx_cnt_reg == CNT_RESET)
        begin
          tx_state_next = TX_IDLE;
          tx_sym_next = SYM_IDLE;
        end
      end
      default:
      begin
        tx_state_next = TX_IDLE;
        tx_sym_next = SYM_IDLE;
      end
    endcase
  end

  // transmit serialiser registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= CNT_RESET;
      tx_bits_reg <= 2'h0;
      tx_sh_reg <= 4'h0;
      tx_bit_reg <= 1'b0;
      tx_sym_reg <= SYM_IDLE;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bits_reg <= tx_bits_next;
      tx_sh_reg <= tx_sh_next;
      tx_bit_reg <= tx_bit_next;
      tx_sym_reg <= tx_sym_next;
    end
  end

  // carrier sense and receive data delay next state
  always_comb
  begin
    crs_state_next = crs_state_reg;
    crs_cnt_next = crs_cnt_reg;
    crs_next = crs_reg;
    case (crs_state_reg)
      CRS_IDLE:
      begin
        // start only with signal detect active
        if (sd_reg && line_rx_sym_i == SYM_J)
        begin
          crs_cnt_next = cnt_t'(RX_CRS_ON_CYC) - 8'h01;
          crs_state_next = CRS_ON_WAIT;
        end
      end
      CRS_ON_WAIT:
      begin
        crs_cnt_next = crs_cnt_reg - 8'h01;
        if (!sd_reg)
          crs_state_next = CRS_IDLE;
        else if (crs_cnt_reg == CNT_RESET)
        begin
          crs_next = 1'b1;
          crs_state_next = CRS_CARRIER;
        end
      end
      CRS_CARRIER:
      begin
        // end group or loss of signal starts the off delay
        if (line_rx_sym_i == SYM_T || !sd_reg)
        begin
          crs_cnt_next = cnt_t'(RX_CRS_OFF_CYC) - 8'h01;
          crs_state_next = CRS_OFF_WAIT;
        end
      end
      CRS_OFF_WAIT:
      begin
        crs_cnt_next = crs_cnt_reg - 8'h01;
        if (crs_cnt_reg == CNT_RESET)
        begin
          crs_next = 1'b0;
          crs_state_next = CRS_IDLE;
        end
      end
      default:
      begin
        crs_state_next = CRS_IDLE;
        crs_next = 1'b0;
      end
    endcase
    // data passes a fixed delay line
    in_dv = (line_rx_sym_i == SYM_DATA) &&
      (crs_state_reg == CRS_ON_WAIT || crs_state_reg == CRS_CARRIER);
    // same edge count as carrier off: sampled at edge k, shown after k+24
    dv_pipe_next = {dv_pipe_reg[RX_DATA_CYC-1:0], in_dv};
    bit_pipe_next = {bit_pipe_reg[RX_DATA_CYC-1:0], line_rx_bit_i & in_dv};
  end

  // carrier sense and delay line registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crs_state_reg <= CRS_IDLE;
      crs_cnt_reg <= CNT_RESET;
      crs_reg <= 1'b0;
      dv_pipe_reg <= '0;
      bit_pipe_reg <= '0;
    end
    else
    begin
      crs_state_reg <= crs_state_next;
      crs_cnt_reg <= crs_cnt_next;
      crs_reg <= crs_next;
      dv_pipe_reg <= dv_pipe_next;
      bit_pipe_reg <= bit_pipe_next;
    end
  end

  // receive clock divider next state
  always_comb
  begin
    half_cyc = slow ? cnt_t'(RXCLK_HALF_10_CYC) : cnt_t'(RXCLK_HALF_100_CYC);
    src_next = (crs_state_reg != CRS_IDLE);
    rxclk_next = rxclk_reg;
    rxclk_cnt_next = rxclk_cnt_reg + 8'h01;
    // a source change restarts the phase, only stretching it
    if (src_next != src_reg)
      rxclk_cnt_next = CNT_RESET;
    else if (rxclk_cnt_reg >= half_cyc - 8'h01)
    begin
      rxclk_next = ~rxclk_reg;
      rxclk_cnt_next = CNT_RESET;
    end
  end

  // receive clock registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rxclk_reg <= 1'b0;
      rxclk_cnt_reg <= CNT_RESET;
      src_reg <= 1'b0;
    end
    else
    begin
      rxclk_reg <= rxclk_next;
      rxclk_cnt_reg <= rxclk_cnt_next;
      src_reg <= src_next;
    end
  end

  // outputs straight from registers
  assign line_tx_bit_o = tx_bit_reg;
  assign line_tx_sym_o = tx_sym_reg;
  assign crs_o = crs_reg;
  assign rx_dv_o = dv_pipe_reg[RX_DATA_CYC];
  assign rx_bit_o = bit_pipe_reg[RX_DATA_CYC];
  assign rx_clk_o = rxclk_reg;
endmodule

`default_nettype wire

//--- inc/mii_lat_pkg.sv
// constants for the mac-side data port latency block
// assumes clk_i runs at 100 MHz, so one cycle is one 100 Mb/s bit time
package mii_lat_pkg;
  // clock and bit times
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_100_NS = 10;
  localparam int BIT_10_NS = 100;
  localparam int BIT_100_CYC = (BIT_100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_10_CYC = (BIT_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // transmit latencies in bit times (10 Mb/s one in tenths of a bit)
  localparam int TX100_START_BITS = 5;
  localparam int TX100_END_BITS = 5;
  localparam int TX10_START_TENTHS = 35;
  localparam int TX100_START_CYC = TX100_START_BITS * BIT_100_CYC;
  localparam int TX100_END_CYC = TX100_END_BITS * BIT_100_CYC;
  localparam int TX10_START_CYC = (TX10_START_TENTHS * BIT_10_CYC + 9) / 10;
  // code group length on the line
  localparam int CODE_GROUP_BITS = 5;
  localparam int CODE_GROUP_CYC = CODE_GROUP_BITS * BIT_100_CYC;
  // receive latencies in bit times
  localparam int RX_CRS_ON_BITS = 20;
  localparam int RX_DATA_BITS = 24;
  localparam int RX_CRS_OFF_BITS = 24;
  localparam int RX_CRS_ON_CYC = RX_CRS_ON_BITS * BIT_100_CYC;
  localparam int RX_DATA_CYC = RX_DATA_BITS * BIT_100_CYC;
  localparam int RX_CRS_OFF_CYC = RX_CRS_OFF_BITS * BIT_100_CYC;
  // receive clock half periods
  localparam int RXCLK_HALF_100_NS = 20;
  localparam int RXCLK_HALF_10_NS = 200;
  localparam int RXCLK_HALF_100_CYC = RXCLK_HALF_100_NS / CLK_PERIOD_NS;
  localparam int RXCLK_HALF_10_CYC = RXCLK_HALF_10_NS / CLK_PERIOD_NS;
  // transmit fifo shape: {tx_en, txd[3:0]}
  localparam int TXF_WIDTH = 5;
  localparam int TXF_DEPTH = 32;
  // reset values
  localparam logic [7:0] CNT_RESET = 8'h00;
  // counter type
  typedef logic [7:0] cnt_t;
  // line code group marker
  typedef enum logic [1:0] {SYM_IDLE, SYM_J, SYM_DATA, SYM_T} line_sym_e;
endpackage

//--- bench/phy_mac_data_port_properties.sv
// checker for the mac-side data port, bound to the top module's ports
// assumes mode pins and signal detect change only while the port is idle
`timescale 1ns/10ps
`default_nettype none
module phy_mac_data_port_properties
  import mii_lat_pkg::*;
(
  // clock, reset and modes
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic speed_10_i,
  // line side
  input wire logic signal_detect_i,
  input wire logic line_rx_bit_i,
  input wire logic [1:0] line_rx_sym_i,
  input wire logic line_tx_bit_o,
  input wire logic [1:0] line_tx_sym_o,
  // mac receive side
  input wire logic crs_o,
  input wire logic rx_dv_o,
  input wire logic rx_bit_o,
  input wire logic rx_clk_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  crs_on_a: assert property ($rose(crs_o) |-> $past(line_rx_sym_i, 21) == SYM_J
    && $past(line_rx_sym_i, 22) != SYM_J) else $error("carrier on at wrong time");
  rx_data_a: assert property (rx_dv_o |-> $past(line_rx_sym_i, 25) == SYM_DATA
    && rx_bit_o == $past(line_rx_bit_i, 25)) else $error("receive data misaligned");
  quiet_bit_a: assert property (!rx_dv_o |-> !rx_bit_o)
    else $error("receive bit set without valid");
  crs_off_a: assert property ($fell(crs_o) |-> $past(line_rx_sym_i, 25) == SYM_T
    && $past(line_rx_sym_i, 26) != SYM_T) else $error("carrier off at wrong time");
  sd_gate_a: assert property ($rose(crs_o) |-> $past(signal_detect_i, 23))
    else $error("carrier without signal detect");
  j_group_a: assert property ($rose(line_tx_sym_o == SYM_J) |->
    (line_tx_sym_o == SYM_J) [*5] ##1 (line_tx_sym_o == SYM_DATA))
    else $error("start group length wrong");
  t_group_a: assert property ($rose(line_tx_sym_o == SYM_T) |->
    ($past(line_tx_sym_o) == SYM_DATA) ##0 (line_tx_sym_o == SYM_T) [*5]
    ##1 (line_tx_sym_o == SYM_IDLE)) else $error("end group length wrong");
  slow_bit_a: assert property (speed_10_i && $rose(line_tx_sym_o == SYM_DATA)
    |=> $stable(line_tx_bit_o) [*8]) else $error("slow bit too short");
  slow_nogrp_a: assert property (speed_10_i |-> line_tx_sym_o != SYM_J)
    else $error("start group at 10 Mb/s");
  rxclk_phase_a: assert property ($changed(rx_clk_o) |=> $stable(rx_clk_o))
    else $error("receive clock phase too short");
endmodule
bind phy_mac_data_port phy_mac_data_port_properties chk (.clk_i(clk_i), .rst_i(rst_i),
  .speed_10_i(speed_10_i), .signal_detect_i(signal_detect_i),
  .line_rx_bit_i(line_rx_bit_i), .line_rx_sym_i(line_rx_sym_i),
  .line_tx_bit_o(line_tx_bit_o), .line_tx_sym_o(line_tx_sym_o), .crs_o(crs_o),
  .rx_dv_o(rx_dv_o), .rx_bit_o(rx_bit_o), .rx_clk_o(rx_clk_o));
`default_nettype wire

//--- bench/mac_model.sv
// behavioural mac transmitter driving the link side of the port
// assumes the bench fills frame_q with whole frames at once
`timescale 1ns/10ps
`default_nettype none
module mac_model
(
  // mac transmit clock
  input wire logic link_clk_i,
  // transmit signals toward the port
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  // nibbles waiting to be sent, one per clock
  logic [3:0] frame_q[$];
  initial
  begin
    tx_en_o = 1'b0;
    txd_o = 4'h0;
  end
  always @(posedge link_clk_i)
  begin
    #1;
    if (frame_q.size() > 0)
    begin
      tx_en_o = 1'b1;
      txd_o = frame_q.pop_front();
    end
    else
    begin
      // idle data toggles so stale values never look valid
      tx_en_o = 1'b0;
      txd_o = ~txd_o;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the mac-side data port
// assumes a 100 MHz system clock and a 125 ns link clock
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import mii_lat_pkg::*;
;
  logic clk_i, rst_i, speed_10_i, serial_mode_i, link_clk_i, tx_en_i;
  logic [3:0] txd_i;
  logic tx_fifo_ready_o, line_tx_bit_o, signal_detect_i, line_rx_bit_i;
  logic [1:0] line_tx_sym_o, line_rx_sym_i;
  logic crs_o, rx_dv_o, rx_bit_o, rx_clk_o;
  int bad_count, n_compared, cycles, n;
  logic [31:0] seed;
  logic [3:0] sent[$];
  logic bits[$];
  logic [1:0] v;
  phy_mac_data_port dut (.clk_i(clk_i), .rst_i(rst_i), .speed_10_i(speed_10_i),
    .serial_mode_i(serial_mode_i), .link_clk_i(link_clk_i), .tx_en_i(tx_en_i),
    .txd_i(txd_i), .tx_fifo_ready_o(tx_fifo_ready_o), .line_tx_bit_o(line_tx_bit_o),
    .line_tx_sym_o(line_tx_sym_o), .signal_detect_i(signal_detect_i),
    .line_rx_bit_i(line_rx_bit_i), .line_rx_sym_i(line_rx_sym_i), .crs_o(crs_o),
    .rx_dv_o(rx_dv_o), .rx_bit_o(rx_bit_o), .rx_clk_o(rx_clk_o));
  mac_model mac (.link_clk_i(link_clk_i), .tx_en_o(tx_en_i), .txd_o(txd_i));
  // clocks, the link one offset in phase
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    link_clk_i = 1'b0;
    #3.3;
    forever #62.5 link_clk_i = ~link_clk_i;
  end
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      summarize();
    end
  end
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // watched signal chosen by index
  function automatic logic [1:0] pick(input int w);
    return (w == 0) ? line_tx_sym_o : (w == 1) ? {1'b0, tx_fifo_ready_o} : {1'b0, rx_clk_o};
  endfunction
  task automatic summarize();
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      $display("unexpected at %0t: %s", $time, msg);
      bad_count++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_on(input int w, input logic [1:0] x, input int lim);
    int k;
    k = 0;
    while (pick(w) !== x && k < lim)
    begin
      tick(1);
      k++;
    end
    chk(k < lim, "wait ran out");
  endtask
  task automatic run_len(input int w, input logic [1:0] x, output int k);
    k = 0;
    while (pick(w) === x && k < 60)
    begin
      tick(1);
      k++;
    end
  endtask
  task automatic send(input int k);
    sent = {};
    repeat (k)
    begin
      seed = xs(seed);
      sent.push_back(seed[3:0]);
      mac.frame_q.push_back(seed[3:0]);
    end
  endtask
  task automatic drive(input logic [1:0] s, input logic b, input int k);
    line_rx_sym_i = s;
    line_rx_bit_i = b;
    tick(k);
  endtask
  // one received frame, crs and data checked against line timing
  task automatic rx_frame(input logic live);
    logic got[$];
    bits = {};
    repeat (16)
    begin
      seed = xs(seed);
      bits.push_back(seed[0]);
    end
    fork
      begin
        drive(SYM_J, 1'b1, 5);
        foreach (bits[i]) drive(SYM_DATA, bits[i], 1);
        drive(SYM_T, 1'b1, 5);
        drive(SYM_IDLE, ~bits[15], 1);
      end
      begin
        tick(20);
        chk(crs_o === 1'b0, "carrier early");
        tick(1);
        chk(crs_o === live, "carrier on");
        tick(24);
        chk(crs_o === live, "carrier held");
        tick(1);
        chk(crs_o === 1'b0, "carrier off");
      end
      repeat (80)
      begin
        tick(1);
        if (rx_dv_o === 1'b1)
          got.push_back(rx_bit_o);
      end
    join
    chk(got.size() == (live ? 16 : 0), "receive count");
    foreach (got[i]) chk(got[i] === bits[i], "receive bit");
  endtask
  // half period of the receive clock in idle
  task automatic rx_half(input int want);
    v = pick(2) ^ 2'b01;
    wait_on(2, v, 60);
    run_len(2, v, n);
    chk(n == want, "receive clock half period");
  endtask
  initial
  begin
    {rst_i, speed_10_i, serial_mode_i, signal_detect_i} = 4'h9;
    {line_rx_bit_i, line_rx_sym_i, bad_count, n_compared, cycles} = '0;
    seed = 32'h0000_28C0;
    repeat (3) @(posedge link_clk_i);
    tick(1);
    rst_i = 1'b0;
    tick(60);
    chk(tx_fifo_ready_o === 1'b1 && line_tx_sym_o === SYM_IDLE, "reset state");
    // 100 Mb/s frame: start group, first nibble lsb first, end group
    send(6);
    wait_on(0, SYM_J, 400);
    run_len(0, SYM_J, n);
    chk(n == CODE_GROUP_CYC, "start group");
    for (int i = 0; i < 4; i++)
    begin
      chk(line_tx_bit_o === sent[0][i], "fast bit");
      tick(1);
    end
    wait_on(0, SYM_T, 400);
    run_len(0, SYM_T, n);
    chk(n == CODE_GROUP_CYC, "end group");
    // 10 Mb/s mii frame, every bit at mid bit time
    speed_10_i = 1'b1;
    tick(60);
    send(8);
    // falling sample pushes one link period before a rising one would
    while (tx_en_i !== 1'b1)
    begin
      tick(1);
    end
    n = 0;
    while (line_tx_sym_o !== SYM_DATA && n < 200)
    begin
      tick(1);
      n++;
    end
    chk(n >= TX10_START_CYC + 12 && n <= TX10_START_CYC + 16, "slow start");
    wait_on(0, SYM_DATA, 2000);
    tick(BIT_10_CYC / 2);
    for (int k = 0; k < 32; k++)
    begin
      chk(line_tx_bit_o === sent[k / 4][k % 4], "slow bit");
      tick(BIT_10_CYC);
    end
    wait_on(0, SYM_IDLE, 2000);
    // serial mode frame, one bit per word
    serial_mode_i = 1'b1;
    tick(60);
    send(3);
    wait_on(0, SYM_DATA, 2000);
    tick(BIT_10_CYC / 2);
    chk(line_tx_bit_o === sent[0][0], "serial bit");
    wait_on(0, SYM_IDLE, 3000);
    serial_mode_i = 1'b0;
    tick(60);
    // long frame fills the buffer until it refuses, then drains
    send(60);
    wait_on(1, 2'b00, 3000);
    wait_on(1, 2'b01, 9000);
    send(2);
    wait_on(0, SYM_IDLE, 9000);
    chk(tx_fifo_ready_o === 1'b1, "buffer drained");
    rx_half(RXCLK_HALF_10_CYC);
    speed_10_i = 1'b0;
    tick(60);
    rx_half(RXCLK_HALF_100_CYC);
    // receive with and without signal detect
    rx_frame(1'b1);
    tick(40);
    signal_detect_i = 1'b0;
    tick(10);
    rx_frame(1'b0);
    summarize();
  end
endmodule
`default_nettype wire
